/* File: serial_mode_ctrl_link_status.sv */
// Mode and modem control plus link status logic of an enhanced serial port.
// Assumes receiver, transmitter and interrupt logic on core_clk, modem pins asynchronous.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps

module serial_mode_ctrl_link_status #(
	parameter int RX_DEPTH = 16
) (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Receiver front end.
	input  wire logic        rx_char_done,
	input  wire logic        rx_char_parity_err,
	input  wire logic        rx_char_frame_err,
	input  wire logic        rx_char_break,
	input  wire logic        rx_char_read,
	input  wire logic        rx_soft_reset,
	input  wire logic        fifos_enabled,
	// Transmitter.
	input  wire logic        tx_data_write,
	input  wire logic        tx_holding_empty,
	input  wire logic        tx_front_idle,
	input  wire logic        tx_fifo_enabled,
	// Interrupt logic.
	input  wire logic        irq_request,
	input  wire logic        link_irq_enable,
	output logic             irq_out,
	output logic             link_status_irq,
	// Modem pins, active low.
	input  wire logic        cts_in_b,
	input  wire logic        dsr_in_b,
	input  wire logic        ri_in_b,
	input  wire logic        dcd_in_b,
	output logic             dtr_out_b,
	output logic             rts_out_b,
	// Modem lines seen by the status logic, high when asserted.
	output logic             cts_line,
	output logic             dsr_line,
	output logic             ri_line,
	output logic             dcd_line,
	// Mode outputs.
	output logic [2:0]       op_mode,
	output logic             op_mode_reserved,
	output logic             dma_to_data_regs,
	output logic             tx_deferral_active,
	output logic             fifo_flush,
	output logic             status_irq_clear,
	output logic             aux_status_clear
);

	// =====================================================================
	// Parameter check.
	// =====================================================================
	localparam int CW = $clog2(RX_DEPTH + 1);

	if (RX_DEPTH < 2 || RX_DEPTH > 64) begin : g_bad_depth
		$error("RX_DEPTH must lie between 2 and 64.");
	end

	// =====================================================================
	// State.
	// =====================================================================
	typedef struct packed {
		logic [3:0]                ctl_low;
		logic [2:0]                mode;
		logic                      loop;
		logic                      ext_sel;
		logic                      ovr;
		logic                      par;
		logic                      frm;
		logic                      break_flag;
		logic                      summary;
		logic                      tx_ready;
		logic                      tx_empty;
		logic [RX_DEPTH-1:0][2:0]  tags;
		logic [CW-1:0]             count;
		logic                      revealed;
		logic                      wr_pend;
		logic [7:0]                wr_addr;
		logic [31:0]               rdata;
		logic [3:0]                mdm_s1;
		logic [3:0]                mdm_s2;
		logic [3:0]                lines;
		logic                      dtr_b;
		logic                      rts_b;
		logic                      flush;
	} state_t;

	localparam logic [CW-1:0] DEPTH_C = CW'(RX_DEPTH);
	localparam logic [CW-1:0] ONE_C   = CW'(1);

	state_t q;
	state_t d;

	logic                     acc;
	logic                     lsr_rd;
	logic                     full;
	logic                     pop;
	logic                     push;
	logic                     err_gate;
	logic [2:0]               new_tag;
	logic [2:0]               eff_mode;
	logic [7:0]               mmc_view;
	logic [7:0]               ext1_view;
	logic [7:0]               lsr_view;
	logic [RX_DEPTH-1:0][2:0] tags_n;
	logic [CW-1:0]            cnt_n;

	// =====================================================================
	// Register views.
	// =====================================================================
	always_comb begin
		mmc_view = serial_mode_ctrl_pkg::MMC_RESET;
		mmc_view[3:0] = q.ctl_low;
		if (q.ext_sel) begin
			mmc_view[serial_mode_ctrl_pkg::MMC_MODE_LSB +: 3] = q.mode;
		end else begin
			mmc_view[serial_mode_ctrl_pkg::MMC_LOOP_BIT] = q.loop;
		end
		ext1_view = serial_mode_ctrl_pkg::EXT1_RESET;
		ext1_view[serial_mode_ctrl_pkg::EXT1_SELECT_BIT] = q.ext_sel;
		ext1_view[serial_mode_ctrl_pkg::EXT1_LOOP_BIT] = q.loop;
		lsr_view = 8'h00;
		lsr_view[serial_mode_ctrl_pkg::LSR_RX_DATA_AVAILABLE_BIT] = (q.count != '0);
		lsr_view[serial_mode_ctrl_pkg::LSR_OVR_BIT] = q.ovr;
		lsr_view[serial_mode_ctrl_pkg::LSR_PAR_BIT] = q.par;
		lsr_view[serial_mode_ctrl_pkg::LSR_FRM_BIT] = q.frm;
		lsr_view[serial_mode_ctrl_pkg::LSR_BRK_BIT] = q.break_flag;
		lsr_view[serial_mode_ctrl_pkg::LSR_TX_READY_FLAG_BIT] = q.tx_ready;
		lsr_view[serial_mode_ctrl_pkg::LSR_TX_EMPTY_FLAG_BIT] = q.tx_empty;
		lsr_view[serial_mode_ctrl_pkg::LSR_SUMMARY_BIT] = q.summary;
	end

	// =====================================================================
	// Next state.
	// =====================================================================
	always_comb begin
		d = q;
		d.flush = 1'b0;

		// =====================================================================
		// Modem pins pass two flip-flops before use.
		// =====================================================================
		d.mdm_s1 = {cts_in_b, dsr_in_b, ri_in_b, dcd_in_b};
		d.mdm_s2 = q.mdm_s1;

		// =====================================================================
		// Bus address phase: reads sample the register view at once.
		// =====================================================================
		acc = hsel & hready & (htrans == serial_mode_ctrl_pkg::HTRANS_NONSEQ ||
			htrans == 2'h3);
		lsr_rd = acc & ~hwrite & (haddr[7:0] == serial_mode_ctrl_pkg::LSR_OFFSET);
		// A stalled data phase keeps its write pending until hready returns.
		if (hready) begin
			d.wr_pend = acc & hwrite;
		end
		if (acc) begin
			d.wr_addr = haddr[7:0];
		end
		if (acc & ~hwrite) begin
			if (haddr[7:0] == serial_mode_ctrl_pkg::MMC_OFFSET) begin
				d.rdata = {24'h000000, mmc_view};
			end else if (haddr[7:0] == serial_mode_ctrl_pkg::EXT1_OFFSET) begin
				d.rdata = {24'h000000, ext1_view};
			end else if (lsr_rd) begin
				d.rdata = {24'h000000, lsr_view};
			end else begin
				d.rdata = 32'h00000000;
			end
		end

		// =====================================================================
		// Bus data phase: writes take hwdata.
		// =====================================================================
		if (q.wr_pend & hready) begin
			if (q.wr_addr == serial_mode_ctrl_pkg::MMC_OFFSET) begin
				d.ctl_low = hwdata[3:0];
				if (q.ext_sel) begin
					d.mode = hwdata[serial_mode_ctrl_pkg::MMC_MODE_LSB +: 3];
				end else begin
					d.loop = hwdata[serial_mode_ctrl_pkg::MMC_LOOP_BIT];
				end
			end else if (q.wr_addr == serial_mode_ctrl_pkg::EXT1_OFFSET) begin
				d.ext_sel = hwdata[serial_mode_ctrl_pkg::EXT1_SELECT_BIT];
				d.loop = hwdata[serial_mode_ctrl_pkg::EXT1_LOOP_BIT];
			end
			// A write to link status stores nothing.
		end

		// =====================================================================
		// Receive storage: FIFO mode holds RX_DEPTH characters, else one.
		// =====================================================================
		eff_mode = q.ext_sel ? q.mode : serial_mode_ctrl_pkg::MODE_SERIAL;
		err_gate = (eff_mode != serial_mode_ctrl_pkg::MODE_REMOTE);
		full = fifos_enabled ? (q.count == DEPTH_C) : (q.count != '0);
		pop = rx_char_read & (q.count != '0);
		push = rx_char_done & ~full;
		new_tag = {rx_char_break, rx_char_frame_err, rx_char_parity_err} &
			{3{err_gate}};
		tags_n = q.tags;
		cnt_n = q.count;
		if (pop) begin
			tags_n = {3'h0, q.tags[RX_DEPTH-1:1]};
			cnt_n = q.count - ONE_C;
			d.revealed = 1'b0;
		end
		if (push) begin
			tags_n[cnt_n] = new_tag;
			cnt_n = cnt_n + ONE_C;
		end
		d.tags = tags_n;
		d.count = cnt_n;

		// =====================================================================
		// Sticky flags: clears first, so a same-cycle event still sets.
		// =====================================================================
		if (lsr_rd | rx_soft_reset) begin
			d.ovr = 1'b0;
			d.par = 1'b0;
			d.frm = 1'b0;
			d.break_flag = 1'b0;
		end
		if (lsr_rd) begin
			d.summary = 1'b0;
		end
		if (rx_char_done & full) begin
			d.ovr = 1'b1;
		end
		if (cnt_n != '0 && !d.revealed) begin
			d.revealed = 1'b1;
			d.par = d.par | tags_n[0][0];
			d.frm = d.frm | tags_n[0][1];
			d.break_flag = d.break_flag | tags_n[0][2];
		end
		if (fifos_enabled & push & (|new_tag)) begin
			d.summary = 1'b1;
		end
		if (!fifos_enabled) begin
			d.summary = 1'b0;
		end

		// =====================================================================
		// Mode change flushes storage and clears pending status.
		// =====================================================================
		if (d.mode != q.mode) begin
			d.flush = 1'b1;
			d.tags = '0;
			d.count = '0;
			d.revealed = 1'b0;
			d.ovr = 1'b0;
			d.par = 1'b0;
			d.frm = 1'b0;
			d.break_flag = 1'b0;
			d.summary = 1'b0;
		end

		// =====================================================================
		// Transmitter flags: a data write clears, as empty input lags it.
		// =====================================================================
		if (tx_data_write) begin
			d.tx_ready = 1'b0;
			d.tx_empty = 1'b0;
		end else begin
			d.tx_ready = tx_holding_empty;
			d.tx_empty = tx_holding_empty & tx_front_idle;
		end

		// =====================================================================
		// Modem lines and pins.
		// =====================================================================
		if (!d.loop) begin
			d.lines = ~q.mdm_s2;
			d.dtr_b = ~d.ctl_low[serial_mode_ctrl_pkg::MMC_TERM_BIT];
			d.rts_b = ~d.ctl_low[serial_mode_ctrl_pkg::MMC_SEND_BIT];
		end else begin
			d.dtr_b = 1'b1;
			d.rts_b = 1'b1;
			if (d.ext_sel) begin
				d.lines = {d.ctl_low[1], d.ctl_low[0], d.ctl_low[0], d.ctl_low[1]};
			end else begin
				d.lines = {d.ctl_low[1], d.ctl_low[0], d.ctl_low[2], d.ctl_low[3]};
			end
		end
	end

	// =====================================================================
	// State register.
	// =====================================================================
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.tx_ready <= 1'b1;
			q.tx_empty <= 1'b1;
			q.mdm_s1 <= 4'hF;
			q.mdm_s2 <= 4'hF;
			q.dtr_b <= 1'b1;
			q.rts_b <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// =====================================================================
	// Outputs.
	// =====================================================================
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;

	// =====================================================================
	// Interrupt outputs.
	// =====================================================================
	assign irq_out = irq_request & (q.ext_sel | q.loop |
		q.ctl_low[serial_mode_ctrl_pkg::MMC_GATE_DFR_BIT]);
	assign link_status_irq = link_irq_enable & (q.ovr | q.par | q.frm | q.break_flag);

	// =====================================================================
	// Modem outputs.
	// =====================================================================
	assign dtr_out_b = q.dtr_b;
	assign rts_out_b = q.rts_b;
	assign cts_line = q.lines[3];
	assign dsr_line = q.lines[2];
	assign ri_line = q.lines[1];
	assign dcd_line = q.lines[0];

	// =====================================================================
	// Mode outputs.
	// =====================================================================
	assign op_mode = q.ext_sel ? q.mode : serial_mode_ctrl_pkg::MODE_SERIAL;
	assign op_mode_reserved = q.ext_sel & (q.mode != serial_mode_ctrl_pkg::MODE_SERIAL) &
		(q.mode != serial_mode_ctrl_pkg::MODE_TWO_IR) &
		(q.mode != serial_mode_ctrl_pkg::MODE_PULSE_IR) &
		(q.mode != serial_mode_ctrl_pkg::MODE_REMOTE);
	assign dma_to_data_regs = q.ext_sel &
		q.ctl_low[serial_mode_ctrl_pkg::MMC_RING_DMA_BIT];
	assign tx_deferral_active = q.ext_sel & tx_fifo_enabled &
		q.ctl_low[serial_mode_ctrl_pkg::MMC_GATE_DFR_BIT];
	assign fifo_flush = q.flush;
	assign status_irq_clear = q.flush;
	assign aux_status_clear = q.flush;

endmodule // serial_mode_ctrl_link_status

/* File: serial_mode_ctrl_pkg.sv */
// Shared constants of the serial mode control and link status block.
// Assumes a 32-bit AHB-Lite register bus with byte addresses on its low eight bits.
package serial_mode_ctrl_pkg;

	// =====================================================================
	// Register map.
	// =====================================================================
	localparam int        ADDR_W            = 8;
	localparam logic [7:0] MMC_OFFSET       = 8'h04;
	localparam logic [7:0] EXT1_OFFSET      = 8'h08;
	localparam logic [7:0] LSR_OFFSET       = 8'h14;

	// =====================================================================
	// Reset values.
	// =====================================================================
	localparam logic [7:0] MMC_RESET        = 8'h00;
	localparam logic [7:0] EXT1_RESET       = 8'h00;
	localparam logic [7:0] LSR_RESET        = 8'h60;

	// =====================================================================
	// Field positions of mode_modem_control.
	// =====================================================================
	localparam int        MMC_TERM_BIT      = 0;
	localparam int        MMC_SEND_BIT      = 1;
	localparam int        MMC_RING_DMA_BIT  = 2;
	localparam int        MMC_GATE_DFR_BIT  = 3;
	localparam int        MMC_LOOP_BIT      = 4;
	localparam int        MMC_MODE_LSB      = 5;
	localparam int        MMC_MODE_W        = 3;

	// =====================================================================
	// Field positions of extended_control_one.
	// =====================================================================
	localparam int        EXT1_SELECT_BIT   = 0;
	localparam int        EXT1_LOOP_BIT     = 4;

	// =====================================================================
	// Field positions of link_status.
	// =====================================================================
	localparam int        LSR_RX_DATA_AVAILABLE_BIT      = 0;
	localparam int        LSR_OVR_BIT       = 1;
	localparam int        LSR_PAR_BIT       = 2;
	localparam int        LSR_FRM_BIT       = 3;
	localparam int        LSR_BRK_BIT       = 4;
	localparam int        LSR_TX_READY_FLAG_BIT     = 5;
	localparam int        LSR_TX_EMPTY_FLAG_BIT     = 6;
	localparam int        LSR_SUMMARY_BIT   = 7;

	// =====================================================================
	// Operating modes and bus encodings.
	// =====================================================================
	typedef enum logic [2:0] {
		MODE_SERIAL   = 3'h0,
		MODE_TWO_IR   = 3'h2,
		MODE_PULSE_IR = 3'h3,
		MODE_REMOTE   = 3'h6
	} op_mode_t;

	localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;

endpackage

/* File: serial_modem_model.sv */
// Behavioural modem facing the port's control pins.
// Assumes active-low pins and offers the ring and carrier levels given at its inputs.
`timescale 1ns/1ps

module serial_modem_model (
	// Port outputs.
	input  logic dtr_out_b,
	input  logic rts_out_b,
	// Levels offered, high when asserted.
	input  logic ring,
	input  logic carrier,
	// Port inputs.
	output logic cts_in_b,
	output logic dsr_in_b,
	output logic ri_in_b,
	output logic dcd_in_b
);
	// Clear to send answers send request; data set ready answers terminal ready.
	assign cts_in_b = rts_out_b;
	assign dsr_in_b = dtr_out_b;
	assign ri_in_b  = ~ring;
	assign dcd_in_b = ~carrier;
endmodule // serial_modem_model

/* File: serial_mode_ctrl_link_status_assertions.sv */
// Port-level checker of the serial mode control and link status block.
// Assumes it is bound into the design and sees only its ports.
`timescale 1ns/1ps

module serial_mode_ctrl_checker #(
	parameter int RX_DEPTH = 16
) (
	// Clock and reset.
	input logic       core_clk,
	input logic       rst_b,
	// Watched ports.
	input logic       irq_out,
	input logic       irq_request,
	input logic       link_status_irq,
	input logic       link_irq_enable,
	input logic       rx_char_done,
	input logic       rx_char_read,
	input logic       rx_soft_reset,
	input logic [2:0] op_mode,
	input logic       op_mode_reserved,
	input logic       fifo_flush,
	input logic       status_irq_clear,
	input logic       aux_status_clear,
	input logic       tx_deferral_active,
	input logic       tx_fifo_enabled,
	input logic       dtr_out_b
);
	// =====================================================================
	// Assertions.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_soft_reset;
		rx_soft_reset && !rx_char_done && !rx_char_read;
	endsequence

	irq_gate_a: assert property (irq_out |-> irq_request)
		else $error("irq out without request");
	ext_irq_a: assert property (irq_request && op_mode != 3'h0 |-> irq_out)
		else $error("extended irq not enabled");
	link_irq_a: assert property (link_status_irq |-> link_irq_enable)
		else $error("link irq while disabled");
	mode_code_a: assert property (
		op_mode_reserved == !(op_mode inside {3'h0, 3'h2, 3'h3, 3'h6}))
		else $error("reserved mode flag wrong");
	clear_group_a: assert property (
		fifo_flush == status_irq_clear && fifo_flush == aux_status_clear)
		else $error("mode change clears differ");
	flush_cause_a: assert property (
		fifo_flush |-> op_mode != $past(op_mode) || op_mode != $past(op_mode, 2))
		else $error("flush without mode change");
	deferral_gate_a: assert property (tx_deferral_active |-> tx_fifo_enabled)
		else $error("deferral without tx fifo");
	soft_clear_a: assert property (s_soft_reset |=> !link_status_irq)
		else $error("soft reset kept error flags");
	reset_state_a: assert property ($rose(rst_b) |-> dtr_out_b && !link_status_irq && !fifo_flush)
		else $error("bad state after reset");
endmodule // serial_mode_ctrl_checker

bind serial_mode_ctrl_link_status serial_mode_ctrl_checker #(.RX_DEPTH(RX_DEPTH)) u_chk (
	.core_clk, .rst_b, .irq_out, .irq_request, .link_status_irq, .link_irq_enable,
	.rx_char_done, .rx_char_read, .rx_soft_reset, .op_mode, .op_mode_reserved,
	.fifo_flush, .status_irq_clear, .aux_status_clear, .tx_deferral_active,
	.tx_fifo_enabled, .dtr_out_b
);

/* File: serial_mode_ctrl_link_status_test.sv */
// Self-checking bench of the serial mode control and link status block.
// Assumes the modem model on the pins and the checker bound into the design.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %0t got %h want %h", $time, g, e); end end

module serial_mode_ctrl_link_status_test;
	typedef struct packed {
		logic [7:0]  ext;
		logic [7:0]  mmc;
		logic [12:0] want;
	} row_t;
	// =====================================================================
	// Signals.
	logic        core_clk, rst_b, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [6:0]  evs;
	logic        rx_char_done, rx_char_parity_err, rx_char_frame_err, rx_char_break;
	logic        rx_char_read, rx_soft_reset, tx_data_write, fifos_enabled;
	logic        tx_holding_empty, tx_front_idle, irq_out, link_status_irq;
	logic        cts_in_b, dsr_in_b, ri_in_b, dcd_in_b, dtr_out_b, rts_out_b;
	logic        cts_line, dsr_line, ri_line, dcd_line, op_mode_reserved;
	logic        dma_to_data_regs, tx_deferral_active;
	logic        tx_fifo_enabled, irq_request, link_irq_enable;
	logic        fifo_flush, status_irq_clear, aux_status_clear;
	logic [2:0]  op_mode;
	wire  [12:0] outs = {op_mode, op_mode_reserved, dtr_out_b, rts_out_b, dma_to_data_regs,
		tx_deferral_active, irq_out, dcd_line, ri_line, dsr_line, cts_line};
	int          n_errors = 0, total_checks = 0, n_flush = 0;
	row_t        rows [11] = '{
		'{8'h00, 8'h00, 13'h0188}, '{8'h00, 8'h0B, 13'h001B}, '{8'h00, 8'h1C, 13'h019C},
		'{8'h00, 8'h13, 13'h0193}, '{8'h01, 8'h43, 13'h081B}, '{8'h01, 8'h6C, 13'h0DF8},
		'{8'h01, 8'hC0, 13'h1998}, '{8'h01, 8'h20, 13'h0798}, '{8'h11, 8'h01, 13'h0196},
		'{8'h11, 8'h02, 13'h0199}, '{8'h01, 8'h10, 13'h0198}};

	assign {rx_char_done, rx_char_parity_err, rx_char_frame_err, rx_char_break,
		rx_char_read, rx_soft_reset, tx_data_write} = evs;

	serial_mode_ctrl_link_status #(.RX_DEPTH(2)) dut (
		.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_char_done, .rx_char_parity_err,
		.rx_char_frame_err, .rx_char_break, .rx_char_read, .rx_soft_reset, .fifos_enabled,
		.tx_data_write, .tx_holding_empty, .tx_front_idle, .tx_fifo_enabled,
		.irq_request, .link_irq_enable, .irq_out, .link_status_irq,
		.cts_in_b, .dsr_in_b, .ri_in_b, .dcd_in_b, .dtr_out_b, .rts_out_b, .cts_line,
		.dsr_line, .ri_line, .dcd_line, .op_mode, .op_mode_reserved, .dma_to_data_regs,
		.tx_deferral_active, .fifo_flush, .status_irq_clear, .aux_status_clear);

	serial_modem_model modem (
		.dtr_out_b, .rts_out_b, .ring(1'h0), .carrier(1'h1),
		.cts_in_b, .dsr_in_b, .ri_in_b, .dcd_in_b);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) if (fifo_flush === 1'b1) n_flush++;

	// =====================================================================
	// Tasks.
	task automatic finish_test();
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic edge_ready();
		int i;
		@(posedge core_clk);
		for (i = 0; hreadyout !== 1'b1; i++) begin
			if (i == 50) begin
				n_errors++;
				finish_test();
			end
			@(posedge core_clk);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		hsel   <= 1'b1;
		htrans <= serial_mode_ctrl_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr  <= {24'h000000, a};
		edge_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		edge_ready();
		rd = hrdata;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h000000, d});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h00000000);
		`CHK(rd, {24'h000000, e})
	endtask

	task automatic lsr_chk(input logic [7:0] e);
		rd_chk(serial_mode_ctrl_pkg::LSR_OFFSET, e);
	endtask

	task automatic ev(input logic [6:0] v);
		@(posedge core_clk);
		evs <= v;
		@(posedge core_clk);
		evs <= 7'h00;
	endtask

	// =====================================================================
	// Main sequence.
	initial begin
		{rst_b, hsel, hwrite, haddr, htrans, hwdata, evs, fifos_enabled} = '0;
		tx_holding_empty = 1'b1;
		tx_front_idle = 1'b1;
		tx_fifo_enabled = 1'b1;
		irq_request = 1'b1;
		link_irq_enable = 1'b1;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		lsr_chk(8'h60);
		rd_chk(serial_mode_ctrl_pkg::MMC_OFFSET, 8'h00);
		rd_chk(8'h10, 8'h00);
		wr_reg(serial_mode_ctrl_pkg::LSR_OFFSET, 8'hFF);
		`CHK(hresp, 1'b0)
		lsr_chk(8'h60);
		wr_reg(serial_mode_ctrl_pkg::EXT1_OFFSET, 8'h10);
		rd_chk(serial_mode_ctrl_pkg::MMC_OFFSET, 8'h10);
		wr_reg(serial_mode_ctrl_pkg::EXT1_OFFSET, 8'h00);
		ev(7'h60);
		lsr_chk(8'h65);
		ev(7'h40);
		lsr_chk(8'h63);
		lsr_chk(8'h61);
		ev(7'h04);
		lsr_chk(8'h60);
		tx_holding_empty <= 1'b0;
		lsr_chk(8'h00);
		tx_holding_empty <= 1'b1;
		tx_front_idle <= 1'b0;
		lsr_chk(8'h20);
		tx_front_idle <= 1'b1;
		fifos_enabled <= 1'b1;
		ev(7'h50);
		ev(7'h40);
		ev(7'h40);
		lsr_chk(8'hEB);
		ev(7'h04);
		lsr_chk(8'h61);
		ev(7'h04);
		lsr_chk(8'h60);
		ev(7'h48);
		lsr_chk(8'hF1);
		ev(7'h04);
		ev(7'h60);
		#1;
		`CHK(link_status_irq, 1'b1)
		@(posedge core_clk);
		link_irq_enable <= 1'b0;
		#1;
		`CHK(link_status_irq, 1'b0)
		@(posedge core_clk);
		link_irq_enable <= 1'b1;
		ev(7'h02);
		lsr_chk(8'hE1);
		ev(7'h04);
		for (int k = 0; k < 11; k++) begin
			wr_reg(serial_mode_ctrl_pkg::EXT1_OFFSET, rows[k].ext);
			wr_reg(serial_mode_ctrl_pkg::MMC_OFFSET, rows[k].mmc);
			repeat (6) @(posedge core_clk);
			`CHK(outs, rows[k].want)
		end
		wr_reg(serial_mode_ctrl_pkg::MMC_OFFSET, 8'h08);
		#1;
		`CHK(tx_deferral_active, 1'b1)
		@(posedge core_clk);
		tx_fifo_enabled <= 1'b0;
		irq_request <= 1'b0;
		#1;
		`CHK(tx_deferral_active, 1'b0)
		`CHK(irq_out, 1'b0)
		@(posedge core_clk);
		tx_fifo_enabled <= 1'b1;
		irq_request <= 1'b1;
		ev(7'h60);
		wr_reg(serial_mode_ctrl_pkg::MMC_OFFSET, 8'h40);
		lsr_chk(8'h60);
		`CHK(n_flush, 6)
		ev(7'h60);
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		lsr_chk(8'h60);
		rd_chk(serial_mode_ctrl_pkg::MMC_OFFSET, 8'h00);
		finish_test();
	end
endmodule // serial_mode_ctrl_link_status_test
